/* File: common/scc_pkg.sv */
// Package for the stack and core configuration register bank.
// Assumes an 8-bit special-function register bus driven by the core.
package scc_pkg;
    // ==========================================================
    // Register addresses
    localparam logic [7:0] SCC_ADDR_SP_LOW = 8'h81;
    localparam logic [7:0] SCC_ADDR_PTR_LOW = 8'h82;
    localparam logic [7:0] SCC_ADDR_PTR_HIGH = 8'h83;
    localparam logic [7:0] SCC_ADDR_CONFIG = 8'haf;
    localparam logic [7:0] SCC_ADDR_SP_HIGH = 8'hb7;
    localparam logic [7:0] SCC_ADDR_BOUNDARY = 8'hbf;
    // ==========================================================
    // Reset values
    localparam logic [15:0] SCC_RST_PTR = 16'h0000;
    localparam logic [7:0] SCC_RST_SP_LOW = 8'h00;
    localparam logic [2:0] SCC_RST_SP_TOP = 3'h1;
    localparam logic [2:0] SCC_RST_START = 3'h1;
    localparam logic [4:0] SCC_RST_WATERLINE = 5'h00;
    localparam logic [7:0] SCC_RST_CONFIG = 8'h81;
    // ==========================================================
    // Field positions
    localparam int SCC_SPH_RSVD = 7;
    localparam int SCC_SPH_BOTTOM_FLAG = 6;
    localparam int SCC_BND_ACTION = 2;
    localparam int SCC_BND_ENABLE = 1;
    localparam int SCC_BND_WL_FLAG = 0;
    localparam int SCC_CFG_UART = 6;
    localparam int SCC_CFG_OWNER = 5;
    localparam int SCC_CFG_MOD = 4;
    // ==========================================================
    // Stack space
    localparam logic [10:0] SCC_XRAM_TOP = 11'h7ff;
endpackage

/* File: design/scc_stack_check.sv */
// Stack address checks: waterline compare and bottom compare.
// Assumes the register bank feeds it stable register values.
`timescale 1ns/1ns
module scc_stack_check (
    // Stack state
    input wire logic [10:0] i_stack_addr,
    input wire logic [10:0] i_new_addr,
    input wire logic [2:0] i_start_bits,
    input wire logic [4:0] i_waterline,
    // Results
    output logic o_waterline_hit,
    output logic o_below_start
);
    // ==========================================================
    // Waterline at top minus setting; zero setting switches it off
    always_comb begin
        o_waterline_hit = (i_waterline != 5'h00) &&
            (i_stack_addr >= (scc_pkg::SCC_XRAM_TOP - {6'h00, i_waterline}));
        o_below_start = i_new_addr < {i_start_bits, 8'h00};
    end
endmodule

/* File: design/scc_regs.sv */
// Stack pointer, data pointer, stack boundary and core configuration registers.
// Assumes a single-cycle special-function register bus from the core, and a
// push/pop strobe from the execution unit for stack pointer movement.
//
// Function
// - Data pointer is one 16-bit value from two byte registers, resets zero.
// - Stack pointer low register holds address bits 7:0, resets zero.
// - High register bits 2:0 hold address bits 10:8, reset 001.
// - High register bits 5:3 hold start address bits 10:8, reset 001.
// - Boundary register bits 7:3 hold five-bit waterline setting, reset zero.
// - Violation raises interrupt when action bit is 0, reset when 1.
// - Boundary bit 1 enables protection, off after reset.
// - Configuration bit 6 selects the enhanced UART checking.
// - Configuration bit 5 gives shared pins to I2C at 0, SPI at 1.
// - Configuration bit 4 enables 38 kHz output modulation.
// - Either low configuration bit enables external moves to 256 bytes.
// - Waterline is top minus setting; reaching it sets flag; zero disables.
// - Writes below the start address are ignored and set the bottom flag.
// - Start bits set top pointer bits; overflow rolls over to start.
`timescale 1ns/1ns
module scc_regs (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Register bus
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    // Stack movement from execution
    input wire logic i_push,
    input wire logic i_pop,
    // Read data
    output logic [7:0] o_reg_rdata,
    // Pointers
    output logic [15:0] o_data_pointer,
    output logic [10:0] o_stack_addr,
    // Violation results
    output logic o_stack_irq,
    output logic o_stack_reset,
    // Configuration outputs
    output logic o_uart_enhanced_select,
    output logic o_shared_serial_owner,
    output logic o_ir_modulation_enable,
    output logic o_xram_movx_enable
);
    // ==========================================================
    // Storage
    logic [7:0] pointer_low_byte;
    logic [7:0] pointer_high_byte;
    logic [10:0] stack_address_bits;
    logic [2:0] stack_start_bits;
    logic sph_reserved;
    logic stack_bottom_flag;
    logic [4:0] waterline_setting;
    logic violation_action;
    logic boundary_protect_enable;
    logic waterline_reached_flag;
    logic [7:0] core_configuration;
    logic [10:0] next_stack_addr;
    logic waterline_hit;
    logic below_start;
    logic wl_hit_d;
    logic sp_write;
    logic [10:0] wr_addr;

    // ==========================================================
    // Write decode
    function automatic logic is_wr(input logic [7:0] addr);
        is_wr = i_reg_wr && (i_reg_addr == addr);
    endfunction

    // Stack pointer write by either byte; a process, so that strobe and address wake it
    always_comb begin
        sp_write = is_wr(scc_pkg::SCC_ADDR_SP_LOW) || is_wr(scc_pkg::SCC_ADDR_SP_HIGH);
    end
    // Candidate stack address as a bus write would leave it
    always_comb begin
        wr_addr = stack_address_bits;
        if (is_wr(scc_pkg::SCC_ADDR_SP_LOW)) begin
            wr_addr[7:0] = i_reg_wdata;
        end
        if (is_wr(scc_pkg::SCC_ADDR_SP_HIGH)) begin
            wr_addr[10:8] = i_reg_wdata[2:0];
        end
    end

    scc_stack_check u_check (
        .i_stack_addr(stack_address_bits),
        .i_new_addr(wr_addr),
        .i_start_bits(stack_start_bits),
        .i_waterline(waterline_setting),
        .o_waterline_hit(waterline_hit),
        .o_below_start(below_start)
    );

    // ==========================================================
    // Next stack address: bus write, push with roll-over, or pop
    always_comb begin
        next_stack_addr = stack_address_bits;
        if (sp_write) begin
            if (!(boundary_protect_enable && below_start)) begin
                next_stack_addr = wr_addr;
            end
        end else if (i_push) begin
            if (stack_address_bits == scc_pkg::SCC_XRAM_TOP) begin
                next_stack_addr = {stack_start_bits, 8'h00};
            end else begin
                next_stack_addr = stack_address_bits + 11'h001;
            end
        end else if (i_pop) begin
            next_stack_addr = stack_address_bits - 11'h001;
        end
    end

    // Stack pointer
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            stack_address_bits <= {scc_pkg::SCC_RST_SP_TOP, scc_pkg::SCC_RST_SP_LOW};
        end else begin
            stack_address_bits <= next_stack_addr;
        end
    end

    // Data pointer bytes
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            pointer_low_byte <= scc_pkg::SCC_RST_PTR[7:0];
            pointer_high_byte <= scc_pkg::SCC_RST_PTR[15:8];
        end else begin
            if (is_wr(scc_pkg::SCC_ADDR_PTR_LOW)) begin
                pointer_low_byte <= i_reg_wdata;
            end
            if (is_wr(scc_pkg::SCC_ADDR_PTR_HIGH)) begin
                pointer_high_byte <= i_reg_wdata;
            end
        end
    end

    // Stack high register fields and bottom flag
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            stack_start_bits <= scc_pkg::SCC_RST_START;
            sph_reserved <= 1'b1;
            stack_bottom_flag <= 1'b0;
        end else begin
            if (is_wr(scc_pkg::SCC_ADDR_SP_HIGH)) begin
                stack_start_bits <= i_reg_wdata[5:3];
                sph_reserved <= i_reg_wdata[scc_pkg::SCC_SPH_RSVD];
            end
            // Set wins over a software clear
            if (sp_write && boundary_protect_enable && below_start) begin
                stack_bottom_flag <= 1'b1;
            end else if (is_wr(scc_pkg::SCC_ADDR_SP_HIGH) &&
                         !i_reg_wdata[scc_pkg::SCC_SPH_BOTTOM_FLAG]) begin
                stack_bottom_flag <= 1'b0;
            end
        end
    end

    // Boundary control register and waterline flag
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            waterline_setting <= scc_pkg::SCC_RST_WATERLINE;
            violation_action <= 1'b0;
            boundary_protect_enable <= 1'b0;
            waterline_reached_flag <= 1'b0;
        end else begin
            if (is_wr(scc_pkg::SCC_ADDR_BOUNDARY)) begin
                waterline_setting <= i_reg_wdata[7:3];
                violation_action <= i_reg_wdata[scc_pkg::SCC_BND_ACTION];
                boundary_protect_enable <= i_reg_wdata[scc_pkg::SCC_BND_ENABLE];
            end
            if (boundary_protect_enable && waterline_hit) begin
                waterline_reached_flag <= 1'b1;
            end else if (is_wr(scc_pkg::SCC_ADDR_BOUNDARY) &&
                         !i_reg_wdata[scc_pkg::SCC_BND_WL_FLAG]) begin
                waterline_reached_flag <= 1'b0;
            end
        end
    end

    // Configuration register
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            core_configuration <= scc_pkg::SCC_RST_CONFIG;
        end else if (is_wr(scc_pkg::SCC_ADDR_CONFIG)) begin
            core_configuration <= i_reg_wdata;
        end
    end

    // ==========================================================
    // Violation events: one pulse on each new waterline hit or bottom write
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            wl_hit_d <= 1'b0;
            o_stack_irq <= 1'b0;
            o_stack_reset <= 1'b0;
        end else begin
            wl_hit_d <= boundary_protect_enable && waterline_hit;
            o_stack_irq <= !violation_action &&
                (((boundary_protect_enable && waterline_hit) && !wl_hit_d) ||
                 (sp_write && boundary_protect_enable && below_start));
            o_stack_reset <= violation_action &&
                (((boundary_protect_enable && waterline_hit) && !wl_hit_d) ||
                 (sp_write && boundary_protect_enable && below_start));
        end
    end

    // Registered outputs
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_data_pointer <= scc_pkg::SCC_RST_PTR;
            o_stack_addr <= {scc_pkg::SCC_RST_SP_TOP, scc_pkg::SCC_RST_SP_LOW};
            o_uart_enhanced_select <= 1'b0;
            o_shared_serial_owner <= 1'b0;
            o_ir_modulation_enable <= 1'b0;
            o_xram_movx_enable <= 1'b1;
        end else begin
            o_data_pointer <= {pointer_high_byte, pointer_low_byte};
            o_stack_addr <= stack_address_bits;
            o_uart_enhanced_select <= core_configuration[scc_pkg::SCC_CFG_UART];
            o_shared_serial_owner <= core_configuration[scc_pkg::SCC_CFG_OWNER];
            o_ir_modulation_enable <= core_configuration[scc_pkg::SCC_CFG_MOD];
            o_xram_movx_enable <= |core_configuration[1:0];
        end
    end

    // Read data, one cycle after a read strobe
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            unique case (i_reg_addr)
                scc_pkg::SCC_ADDR_SP_LOW: o_reg_rdata <= stack_address_bits[7:0];
                scc_pkg::SCC_ADDR_PTR_LOW: o_reg_rdata <= pointer_low_byte;
                scc_pkg::SCC_ADDR_PTR_HIGH: o_reg_rdata <= pointer_high_byte;
                scc_pkg::SCC_ADDR_CONFIG: o_reg_rdata <= core_configuration;
                scc_pkg::SCC_ADDR_SP_HIGH: o_reg_rdata <= {sph_reserved, stack_bottom_flag,
                    stack_start_bits, stack_address_bits[10:8]};
                scc_pkg::SCC_ADDR_BOUNDARY: o_reg_rdata <= {waterline_setting,
                    violation_action, boundary_protect_enable, waterline_reached_flag};
                default: o_reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule

/* File: tb/scc_regs_checker.sv */
// Assertions on the register bank ports, bound into scc_regs.
// Assumes single-cycle bus strobes and a synchronous reset.
`timescale 1ns/1ns
module scc_regs_checker (
    // Clock, reset and bus
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    // Watched outputs
    input wire logic [7:0] o_reg_rdata,
    input wire logic [15:0] o_data_pointer,
    input wire logic [10:0] o_stack_addr,
    input wire logic o_stack_irq,
    input wire logic o_stack_reset,
    input wire logic o_uart_enhanced_select,
    input wire logic o_shared_serial_owner,
    input wire logic o_ir_modulation_enable,
    input wire logic o_xram_movx_enable
);
    // ==========
    // Decodes
    logic cfg_wr;
    logic mapped;
    assign cfg_wr = i_reg_wr && i_reg_addr == scc_pkg::SCC_ADDR_CONFIG;
    assign mapped = i_reg_addr inside {scc_pkg::SCC_ADDR_SP_LOW, scc_pkg::SCC_ADDR_PTR_LOW,
        scc_pkg::SCC_ADDR_PTR_HIGH, scc_pkg::SCC_ADDR_CONFIG, scc_pkg::SCC_ADDR_SP_HIGH,
        scc_pkg::SCC_ADDR_BOUNDARY};
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    // ==========
    // Properties
    a_movx_from_cfg: assert property (cfg_wr |-> ##2
        o_xram_movx_enable == |$past(i_reg_wdata[1:0], 2)) else $error("movx enable wrong");
    a_uart_from_cfg: assert property (cfg_wr |=> ##1
        o_uart_enhanced_select == $past(i_reg_wdata[6], 2)) else $error("uart select wrong");
    a_owner_from_cfg: assert property (cfg_wr ##2 1'b1 |->
        o_shared_serial_owner == $past(i_reg_wdata[5], 2)) else $error("owner wrong");
    a_mod_from_cfg: assert property (cfg_wr |-> ##2
        o_ir_modulation_enable == $past(i_reg_wdata[4], 2)) else $error("modulation wrong");
    a_ptr_low_lag: assert property (i_reg_wr && i_reg_addr == scc_pkg::SCC_ADDR_PTR_LOW |-> ##2
        o_data_pointer[7:0] == $past(i_reg_wdata, 2)) else $error("pointer low wrong");
    a_irq_rst_excl: assert property (!(o_stack_irq && o_stack_reset))
        else $error("irq and reset together");
    a_reset_values: assert property ($past(i_srst) |-> o_stack_addr == 11'h100
        && o_xram_movx_enable && o_reg_rdata == 8'h00) else $error("reset values wrong");
    a_unmapped_zero: assert property (i_reg_rd && !mapped |=>
        o_reg_rdata == 8'h00) else $error("unmapped read not zero");
    // Main scenarios
    cover property (o_stack_irq);
    cover property (o_stack_reset);
    cover property (cfg_wr);
endmodule
bind scc_regs scc_regs_checker chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_data_pointer(o_data_pointer),
    .o_stack_addr(o_stack_addr), .o_stack_irq(o_stack_irq), .o_stack_reset(o_stack_reset),
    .o_uart_enhanced_select(o_uart_enhanced_select),
    .o_shared_serial_owner(o_shared_serial_owner),
    .o_ir_modulation_enable(o_ir_modulation_enable),
    .o_xram_movx_enable(o_xram_movx_enable));

/* File: tb/tb_top.sv */
// Self-checking bench for the register bank.
// Assumes reads answer one cycle after the strobe.
`timescale 1ns/1ns
module tb_top;
    // ==========
    // Signals
    logic i_sys_clk = 1'b0;
    logic i_srst = 1'b1;
    logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00;
    logic i_reg_wr = 1'b0, i_reg_rd = 1'b0, i_push = 1'b0, i_pop = 1'b0;
    logic [7:0] o_reg_rdata;
    logic [15:0] o_data_pointer;
    logic [10:0] o_stack_addr;
    logic o_stack_irq, o_stack_reset, o_uart_enhanced_select, o_shared_serial_owner;
    logic o_ir_modulation_enable, o_xram_movx_enable;
    logic [7:0] exp_q[$];
    logic rd_seen = 1'b0;
    logic [31:0] r;
    logic [7:0] v;
    int bad_count = 0, num_checks = 0, irq_cnt = 0, rsq_cnt = 0;
    localparam logic [7:0] RA[7] = '{8'h81, 8'h82, 8'h83, 8'haf, 8'hb7, 8'hbf, 8'h90};
    localparam logic [7:0] RV[7] = '{8'h00, 8'h00, 8'h00, 8'h81, 8'h89, 8'h00, 8'h00};
    // Clock
    always #5 i_sys_clk = ~i_sys_clk;
    scc_regs DUT (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
        .i_push(i_push), .i_pop(i_pop), .o_reg_rdata(o_reg_rdata),
        .o_data_pointer(o_data_pointer), .o_stack_addr(o_stack_addr),
        .o_stack_irq(o_stack_irq), .o_stack_reset(o_stack_reset),
        .o_uart_enhanced_select(o_uart_enhanced_select),
        .o_shared_serial_owner(o_shared_serial_owner),
        .o_ir_modulation_enable(o_ir_modulation_enable),
        .o_xram_movx_enable(o_xram_movx_enable));
    // ==========
    // Tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic drv(input logic [3:0] k, input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        {i_reg_wr, i_reg_rd, i_push, i_pop} <= k;
        i_reg_addr <= a;
        i_reg_wdata <= d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        drv(4'h8, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        drv(4'h4, a, 8'h00);
    endtask
    task automatic settle;
        repeat (3) drv(4'h0, 8'h00, 8'h00);
        #1;
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Read monitor and pulse counters
    always @(posedge i_sys_clk) begin
        if (rd_seen)
            check(16'(o_reg_rdata), 16'(exp_q.pop_front()));
        rd_seen <= i_reg_rd;
        irq_cnt <= irq_cnt + int'(o_stack_irq);
        rsq_cnt <= rsq_cnt + int'(o_stack_reset);
    end
    // Watchdog
    initial begin
        #20000;
        bad_count++;
        summarize;
    end
    // ==========
    // Scenarios
    initial begin
        void'($urandom(71410));
        repeat (3) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        #1;
        check(16'(o_stack_addr), 16'h0100);
        check(16'(o_xram_movx_enable), 16'h0001);
        for (int i = 0; i < 7; i++)
            rd(RA[i], RV[i]);
        r = $urandom;
        wr(8'h82, r[7:0]);
        wr(8'h83, r[15:8]);
        settle;
        check(o_data_pointer, r[15:0]);
        rd(8'h83, r[15:8]);
        for (int i = 0; i < 8; i++) begin
            v = {1'b1, 3'(i), 2'b00, 2'(i)};
            wr(8'haf, v);
            settle;
            check(16'({o_uart_enhanced_select, o_shared_serial_owner,
                o_ir_modulation_enable, o_xram_movx_enable}), 16'({v[6:4], |v[1:0]}));
        end
        wr(8'hb7, 8'h8a);
        wr(8'h81, 8'h55);
        settle;
        check(16'(o_stack_addr), 16'h0255);
        rd(8'hb7, 8'h8a);
        wr(8'hbf, 8'h02);
        wr(8'hb7, 8'h9b);
        wr(8'hb7, 8'h9a);
        settle;
        check(16'(o_stack_addr), 16'h0355);
        check(16'(irq_cnt), 16'h0001);
        rd(8'hb7, 8'hdb);
        wr(8'hb7, 8'h9b);
        rd(8'hb7, 8'h9b);
        wr(8'hbf, 8'h06);
        wr(8'hb7, 8'h9a);
        settle;
        check(16'({irq_cnt[7:0], rsq_cnt[7:0]}), 16'h0101);
        wr(8'hbf, 8'h0a);
        wr(8'h81, 8'hfd);
        wr(8'hb7, 8'h9f);
        repeat (3) drv(4'h2, 8'h00, 8'h00);
        drv(4'h3, 8'h00, 8'h00);
        drv(4'h1, 8'h00, 8'h00);
        settle;
        check(16'(o_stack_addr), 16'h0300);
        check(16'(irq_cnt), 16'h0002);
        rd(8'hbf, 8'h0b);
        settle;
        summarize;
    end
endmodule
